// ---- lsi_pkg.sv ----
// ****************************************************************
// link status indicator package
// ****************************************************************
package lsi_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] LSI_ADDR_CTRL = 4'h0;
  localparam logic [3:0] LSI_ADDR_STATUS = 4'h1;
  localparam logic [3:0] LSI_ADDR_DIM = 4'h2;
  localparam logic [3:0] LSI_ADDR_DIVIDE = 4'h3;

  // ctrl field positions
  localparam int LSI_CTRL_PS_LO = 0;
  localparam int LSI_CTRL_PS_VALID = 2;
  localparam int LSI_CTRL_SS_CONN = 3;
  localparam int LSI_CTRL_HS_CONN = 4;
  localparam int LSI_CTRL_HS_SUSP = 5;
  localparam int LSI_CTRL_ACTIVITY = 6;

  // status field positions
  localparam int LSI_STAT_BUTTON = 0;
  localparam int LSI_STAT_STRAP_LO = 1;
  localparam int LSI_STAT_STRAP_OK = 3;
  localparam int LSI_STAT_PRESS = 4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] LSI_CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] LSI_DIM_RST = 8'h80;
  localparam logic [15:0] LSI_DIVIDE_RST = 16'h0100;
  localparam logic [31:0] LSI_UNMAPPED_DATA = 32'h0000_0000;

  // ****************************************************************
  // codes and timing
  // ****************************************************************
  localparam logic [1:0] LSI_PS_U0 = 2'h3;
  localparam logic [1:0] LSI_PS_U1 = 2'h2;
  localparam logic [1:0] LSI_PS_U2 = 2'h1;
  localparam logic [1:0] LSI_PS_U3 = 2'h0;
  localparam logic [1:0] LSI_STRAP_40MHZ = 2'h3;
  localparam int LSI_CLK_MHZ = 200;
  localparam int LSI_HEARTBEAT_MS = 250;
  localparam int LSI_HEARTBEAT_CYC = LSI_HEARTBEAT_MS * 1000 * LSI_CLK_MHZ;

  typedef enum logic [1:0] {
    LSI_PS_U3_type_dummy
  } lsi_unused_type;

  typedef struct packed {
    logic ss_conn;
    logic hs_conn;
    logic hs_susp;
    logic activity;
    logic ps_valid;
    logic [1:0] ps_code;
  } lsi_ctrl_type;

  typedef struct packed {
    logic write;
    logic read;
    logic [3:0] address;
    logic [31:0] writedata;
  } lsi_req_type;

endpackage : lsi_pkg

// ---- lsi_top.sv ----
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module lsi_top
  import lsi_pkg::*;
#(
  parameter int HEARTBEAT_CYC = LSI_HEARTBEAT_CYC,
  parameter int PWM_BITS = 8
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // board pins
  input wire logic BUTTON_IN,
  input wire logic [1:0] REF_FREQ_STRAP,
  output logic HEARTBEAT_OUT,
  output logic [1:0] SS_POWER_STATE_CODE,
  output logic HS_SUSPEND_OUT,
  output logic HS_CONNECTED_OUT,
  output logic SS_CONNECTED_OUT,
  output logic ACTIVITY_DIMMER,
  output logic SUSPEND_FADER
);

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  // the heartbeat counter needs a terminal count above zero
  if (HEARTBEAT_CYC < 2) begin : g_bad_heartbeat
    $error("lsi_top: HEARTBEAT_CYC below 2");
  end
  // the dimmer duty is cut from the top bits of an 8-bit register
  if (PWM_BITS < 2) begin : g_bad_pwm_low
    $error("lsi_top: PWM_BITS below 2");
  end
  if (PWM_BITS > 8) begin : g_bad_pwm_high
    $error("lsi_top: PWM_BITS above 8");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic addr_hit(input logic [3:0] addr, input logic [3:0] reg_addr);
    return addr == reg_addr;
  endfunction : addr_hit

  // ****************************************************************
  // bus slave
  // ****************************************************************
  lsi_ctrl_type ctrl_r;
  logic [7:0] dim_r;
  logic [15:0] divide_r;
  logic ack_r;
  logic press_r;
  logic [1:0] btn_sync_r;
  logic btn_prev_r;
  logic [1:0] strap_r;
  logic [1:0] strap_meta_r;
  logic [1:0] strap_sync_r;
  logic [1:0] strap_wait_r;

  wire logic req_w = (AVS_READ || AVS_WRITE) && !ack_r;
  // writes commit at the edge where the master sees waitrequest low
  wire logic wr_take = AVS_WRITE && ack_r;
  wire logic wr_ctrl = wr_take && addr_hit(AVS_ADDRESS, LSI_ADDR_CTRL);
  wire logic wr_dim = wr_take && addr_hit(AVS_ADDRESS, LSI_ADDR_DIM);
  wire logic wr_div = wr_take && addr_hit(AVS_ADDRESS, LSI_ADDR_DIVIDE);
  wire logic clr_press = wr_take && addr_hit(AVS_ADDRESS, LSI_ADDR_STATUS) && AVS_WRITEDATA[LSI_STAT_PRESS];
  // a zero step count would wrap the compare to one step per 65536 periods, so it is stored as one
  wire logic [15:0] div_in = (AVS_WRITEDATA[15:0] == 16'h0000) ? 16'h0001 : AVS_WRITEDATA[15:0];
  // strap is taken once both synchroniser stages hold the pin value
  wire logic strap_take = (strap_wait_r == 2'h2);
  wire logic press_evt = btn_sync_r[1] && !btn_prev_r;
  wire logic strap_ok = (strap_r == LSI_STRAP_40MHZ);

  wire logic [31:0] ctrl_word = {25'h0000000, ctrl_r.activity, ctrl_r.hs_susp, ctrl_r.hs_conn,
                                 ctrl_r.ss_conn, ctrl_r.ps_valid, ctrl_r.ps_code};
  wire logic [31:0] stat_word = {27'h0000000, press_r, strap_ok, strap_r, btn_sync_r[1]};
  wire logic [31:0] rd_mux = (AVS_ADDRESS == LSI_ADDR_CTRL) ? ctrl_word :
                             (AVS_ADDRESS == LSI_ADDR_STATUS) ? stat_word :
                             (AVS_ADDRESS == LSI_ADDR_DIM) ? {24'h000000, dim_r} :
                             (AVS_ADDRESS == LSI_ADDR_DIVIDE) ? {16'h0000, divide_r} :
                             LSI_UNMAPPED_DATA;

  // one wait cycle per access; answer on the second edge
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_r <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      ack_r <= req_w;
      AVS_WAITREQUEST <= !req_w;
      AVS_READDATA <= req_w ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= lsi_ctrl_type'(LSI_CTRL_RST[6:0]);
    end else if (wr_ctrl) begin
      ctrl_r.ps_code <= AVS_WRITEDATA[LSI_CTRL_PS_LO +: 2];
      ctrl_r.ps_valid <= AVS_WRITEDATA[LSI_CTRL_PS_VALID];
      ctrl_r.ss_conn <= AVS_WRITEDATA[LSI_CTRL_SS_CONN];
      ctrl_r.hs_conn <= AVS_WRITEDATA[LSI_CTRL_HS_CONN];
      ctrl_r.hs_susp <= AVS_WRITEDATA[LSI_CTRL_HS_SUSP];
      ctrl_r.activity <= AVS_WRITEDATA[LSI_CTRL_ACTIVITY];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dim_r <= LSI_DIM_RST;
    end else if (wr_dim) begin
      dim_r <= AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      divide_r <= LSI_DIVIDE_RST;
    end else if (wr_div) begin
      divide_r <= div_in;
    end
  end

  // ****************************************************************
  // button
  // ****************************************************************
  // two flops tame the asynchronous button pin
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      btn_sync_r <= 2'h0;
      btn_prev_r <= 1'b0;
    end else begin
      btn_sync_r <= {btn_sync_r[0], BUTTON_IN};
      btn_prev_r <= btn_sync_r[1];
    end
  end

  // press flag: a new press wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      press_r <= 1'b0;
    end else begin
      press_r <= press_evt || (press_r && !clr_press);
    end
  end

  // ****************************************************************
  // strap
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_meta_r <= 2'h0;
      strap_sync_r <= 2'h0;
    end else begin
      strap_meta_r <= REF_FREQ_STRAP;
      strap_sync_r <= strap_meta_r;
    end
  end

  // captured once after reset; later strap changes are ignored
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_wait_r <= 2'h0;
      strap_r <= 2'h0;
    end else begin
      strap_wait_r <= (strap_wait_r == 2'h3) ? 2'h3 : strap_wait_r + 2'h1;
      if (strap_take) begin
        strap_r <= strap_sync_r;
      end
    end
  end

  // ****************************************************************
  // heartbeat
  // ****************************************************************
  logic [31:0] hb_cnt_r;
  wire logic hb_wrap = (hb_cnt_r == 32'(HEARTBEAT_CYC - 1));

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hb_cnt_r <= 32'h0000_0000;
    end else begin
      hb_cnt_r <= hb_wrap ? 32'h0000_0000 : hb_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      HEARTBEAT_OUT <= 1'b0;
    end else if (hb_wrap) begin
      HEARTBEAT_OUT <= !HEARTBEAT_OUT;
    end
  end

  // ****************************************************************
  // pwm engines
  // ****************************************************************
  logic [PWM_BITS-1:0] pwm_cnt_r;
  logic [15:0] step_cnt_r;
  logic [PWM_BITS-1:0] fade_r;
  logic fade_up_r;

  localparam logic [PWM_BITS-1:0] PWM_MAX = {PWM_BITS{1'b1}};
  wire logic fade_on = ctrl_r.hs_susp || (ctrl_r.ps_valid && ctrl_r.ps_code == LSI_PS_U3);
  wire logic pwm_wrap = (pwm_cnt_r == PWM_MAX);
  wire logic step = pwm_wrap && (step_cnt_r >= divide_r - 16'h0001);
  wire logic [PWM_BITS-1:0] dim_duty = dim_r[7 -: PWM_BITS];

  // free-running period counter shared by both engines
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwm_cnt_r <= '0;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + 1'b1;
    end
  end

  // counts whole periods between fade steps
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      step_cnt_r <= 16'h0000;
    end else if (pwm_wrap) begin
      step_cnt_r <= step ? 16'h0000 : step_cnt_r + 16'h0001;
    end
  end

  // duty ramps up to full, then down to zero, while fading is wanted
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fade_r <= '0;
      fade_up_r <= 1'b1;
    end else begin
      if (!fade_on) begin
        fade_r <= '0;
        fade_up_r <= 1'b1;
      end else if (step) begin
        if (fade_up_r) begin
          fade_r <= fade_r + 1'b1;
          fade_up_r <= (fade_r != PWM_MAX - 1'b1);
        end else begin
          fade_r <= fade_r - 1'b1;
          fade_up_r <= (fade_r == {{(PWM_BITS-1){1'b0}}, 1'b1});
        end
      end
    end
  end

  // ****************************************************************
  // indicator outputs
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SS_POWER_STATE_CODE <= LSI_PS_U3;
      HS_SUSPEND_OUT <= 1'b0;
      HS_CONNECTED_OUT <= 1'b0;
      SS_CONNECTED_OUT <= 1'b0;
      ACTIVITY_DIMMER <= 1'b0;
      SUSPEND_FADER <= 1'b0;
    end else begin
      SS_POWER_STATE_CODE <= ctrl_r.ps_valid ? ctrl_r.ps_code : LSI_PS_U3;
      HS_SUSPEND_OUT <= ctrl_r.hs_susp;
      HS_CONNECTED_OUT <= ctrl_r.hs_conn;
      SS_CONNECTED_OUT <= ctrl_r.ss_conn;
      ACTIVITY_DIMMER <= ctrl_r.activity && (pwm_cnt_r < dim_duty);
      SUSPEND_FADER <= fade_on && (pwm_cnt_r < fade_r);
    end
  end

endmodule : lsi_top

// ---- lsi_assertions.sv ----
`timescale 1ns/1ps
// ****************
// port checker
// ****************
module lsi_chk
  import lsi_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // bus
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // pins
  input wire logic BUTTON_IN,
  input wire logic [1:0] REF_FREQ_STRAP,
  input wire logic HEARTBEAT_OUT,
  input wire logic [1:0] SS_POWER_STATE_CODE,
  input wire logic HS_SUSPEND_OUT,
  input wire logic HS_CONNECTED_OUT,
  input wire logic SS_CONNECTED_OUT,
  input wire logic ACTIVITY_DIMMER,
  input wire logic SUSPEND_FADER
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire logic wr_ctrl = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == LSI_ADDR_CTRL;
  wire logic [6:0] outs = {HEARTBEAT_OUT, SS_POWER_STATE_CODE, HS_SUSPEND_OUT, HS_CONNECTED_OUT, SS_CONNECTED_OUT,
    SUSPEND_FADER};
  property p_rst; $rose(RST_N) |-> outs == 7'h00 && AVS_WAITREQUEST; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_one; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  property p_rdz; AVS_WAITREQUEST |-> AVS_READDATA == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside answer");
  property p_ans; $rose(AVS_READ) || $rose(AVS_WRITE) |=> !AVS_WAITREQUEST; endproperty
  a_ans: assert property (p_ans) else $error("no answer one cycle after request");
  property p_ps;
    wr_ctrl |=> ##1 SS_POWER_STATE_CODE == ($past(AVS_WRITEDATA[2], 2) ? $past(AVS_WRITEDATA[1:0], 2) : 2'h0);
  endproperty
  a_ps: assert property (p_ps) else $error("power code wrong");
  property p_conn;
    wr_ctrl |=> ##1 {HS_SUSPEND_OUT, HS_CONNECTED_OUT, SS_CONNECTED_OUT} == $past(AVS_WRITEDATA[5:3], 2);
  endproperty
  a_conn: assert property (p_conn) else $error("link outputs wrong");
  property p_fade; (!HS_SUSPEND_OUT && SS_POWER_STATE_CODE != 2'h0) [*3] |-> !SUSPEND_FADER; endproperty
  a_fade: assert property (p_fade) else $error("fader on while awake");
  property p_hb; $changed(HEARTBEAT_OUT) |=> $stable(HEARTBEAT_OUT) [*7] ##1 $changed(HEARTBEAT_OUT); endproperty
  a_hb: assert property (p_hb) else $error("heartbeat rate wrong");
  c_rd: cover property (AVS_READ && !AVS_WAITREQUEST);
  c_fade: cover property (SUSPEND_FADER);
  c_dim: cover property (ACTIVITY_DIMMER);
endmodule : lsi_chk

bind lsi_top lsi_chk i_chk (.*);

// ---- lsi_board.sv ----
`timescale 1ns/1ps
// ****************
// board button and straps
// ****************
module lsi_board (
  // bench control
  input wire logic press,
  // pins
  output logic BUTTON_IN,
  output logic [1:0] REF_FREQ_STRAP
);
  assign BUTTON_IN = press;
  assign REF_FREQ_STRAP = 2'h3;
endmodule : lsi_board

// ---- lsi_tb.sv ----
`timescale 1ns/1ps
// ****************
// bench
// ****************
module tb;
  import lsi_pkg::*;
  logic CLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, BUTTON_IN, HEARTBEAT_OUT, press, h;
  logic HS_SUSPEND_OUT, HS_CONNECTED_OUT, SS_CONNECTED_OUT, ACTIVITY_DIMMER, SUSPEND_FADER;
  logic [1:0] REF_FREQ_STRAP, SS_POWER_STATE_CODE;
  logic [3:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
  int num_errors = 0, cmp_count = 0, n, m;
  lsi_top #(.HEARTBEAT_CYC(8)) i_dut (.CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .BUTTON_IN(BUTTON_IN), .REF_FREQ_STRAP(REF_FREQ_STRAP),
    .HEARTBEAT_OUT(HEARTBEAT_OUT), .SS_POWER_STATE_CODE(SS_POWER_STATE_CODE), .HS_SUSPEND_OUT(HS_SUSPEND_OUT),
    .HS_CONNECTED_OUT(HS_CONNECTED_OUT), .SS_CONNECTED_OUT(SS_CONNECTED_OUT), .ACTIVITY_DIMMER(ACTIVITY_DIMMER),
    .SUSPEND_FADER(SUSPEND_FADER));
  lsi_board i_board (.press(press), .BUTTON_IN(BUTTON_IN), .REF_FREQ_STRAP(REF_FREQ_STRAP));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  task automatic stop_test;
    if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // holds the request until waitrequest is sampled low
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do begin
      @(posedge CLK);
    end while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CLK);
  endtask : acc
  task automatic t_rst;
    RST_N <= 1'b0;
    repeat (12) @(posedge CLK);
    chk({HEARTBEAT_OUT, SS_POWER_STATE_CODE, HS_SUSPEND_OUT, HS_CONNECTED_OUT, SS_CONNECTED_OUT, ACTIVITY_DIMMER,
      SUSPEND_FADER, AVS_WAITREQUEST}, 32'h001);
    RST_N <= 1'b1;
    @(posedge CLK);
    acc(1'b0, LSI_ADDR_CTRL, 32'h0);
    chk(q, LSI_CTRL_RST);
    acc(1'b0, LSI_ADDR_DIVIDE, 32'h0);
    chk(q, {16'h0, LSI_DIVIDE_RST});
    acc(1'b0, LSI_ADDR_DIM, 32'h0);
    chk(q, {24'h0, LSI_DIM_RST});
    acc(1'b0, 4'hF, 32'h0);
    chk(q, LSI_UNMAPPED_DATA);
  endtask : t_rst
  task automatic t_ps;
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, LSI_ADDR_CTRL, 32'(c));
      repeat (2) @(posedge CLK);
      chk(SS_POWER_STATE_CODE, c[2] ? c[1:0] : 2'h0);
    end
  endtask : t_ps
  task automatic t_conn;
    for (int b = 0; b < 3; b++) begin
      acc(1'b1, LSI_ADDR_CTRL, 32'h8 << b);
      repeat (2) @(posedge CLK);
      chk({HS_SUSPEND_OUT, HS_CONNECTED_OUT, SS_CONNECTED_OUT}, 32'h1 << b);
    end
    acc(1'b1, LSI_ADDR_CTRL, 32'h40);
    n = 0;
    repeat (512) begin
      @(posedge CLK);
      n += ACTIVITY_DIMMER;
    end
    chk(n, 256);
    acc(1'b1, LSI_ADDR_DIM, 32'h40);
    n = 0;
    repeat (512) begin
      @(posedge CLK);
      n += ACTIVITY_DIMMER;
    end
    chk(n, 128);
  endtask : t_conn
  task automatic t_fade(input logic [31:0] v);
    acc(1'b1, LSI_ADDR_DIVIDE, 32'h1);
    acc(1'b1, LSI_ADDR_CTRL, v);
    n = 0;
    m = 0;
    repeat (256) @(posedge CLK) n += SUSPEND_FADER;
    repeat (256) @(posedge CLK) m += SUSPEND_FADER;
    chk(n != m && n + m > 0, 1);
  endtask : t_fade
  task automatic t_btn;
    press <= 1'b1;
    repeat (4) @(posedge CLK);
    acc(1'b0, LSI_ADDR_STATUS, 32'h0);
    chk(q[4:0], 5'h1F);
    press <= 1'b0;
    repeat (4) @(posedge CLK);
    acc(1'b1, LSI_ADDR_STATUS, 32'h10);
    acc(1'b0, LSI_ADDR_STATUS, 32'h0);
    chk(q[4:0], 5'h0E);
  endtask : t_btn
  task automatic t_hb;
    n = 0;
    h = HEARTBEAT_OUT;
    repeat (80) begin
      @(posedge CLK);
      if (HEARTBEAT_OUT !== h) n++;
      h = HEARTBEAT_OUT;
    end
    chk(n, 10);
  endtask : t_hb
  initial begin
    RST_N = 1'b0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 4'h0;
    AVS_WRITEDATA = 32'h0;
    press = 1'b0;
    t_rst();
    t_ps();
    t_conn();
    t_fade(32'h20);
    t_fade(32'h04);
    t_btn();
    t_hb();
    t_rst();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    stop_test();
  end
endmodule : tb
